// ===== src/hv_sync_pkg.sv
// Constants, register map and carrier types of the H/V sync processor.
// Assumes a 50 MHz system clock and a classic Wishbone register bus.
`default_nettype none
package hv_sync_pkg;
	// Clock and count tick rates
	localparam int CLK_HZ = 50_000_000;
	localparam int HTICK_HZ = 2_000_000;
	localparam int VTICK_HZ = 62_500;
	localparam int HTICK_DIV = CLK_HZ / HTICK_HZ;
	localparam int VTICK_DIV = CLK_HZ / VTICK_HZ;
	// Composite extraction delay, rounded up to whole H ticks
	localparam int EXTRACT_NS = 8000;
	localparam int EXTRACT_TICKS =
		(EXTRACT_NS * (HTICK_HZ / 1000) + 999_999) / 1_000_000;
	// Presence limits: longest period for set, silence for clear
	localparam int HPRE_SET_NS = 100_000;
	localparam int HPRE_SET_TICKS =
		HPRE_SET_NS * (HTICK_HZ / 1000) / 1_000_000;
	localparam int HPRE_LOST_MS = 100;
	localparam int HPRE_LOST_TICKS = HPRE_LOST_MS * (HTICK_HZ / 1000);
	localparam int VPRE_SET_US = 25_000;
	localparam int VPRE_SET_TICKS = VPRE_SET_US * VTICK_HZ / 1_000_000;
	localparam int VPRE_LOST_MS = 100;
	localparam int VPRE_LOST_TICKS = VPRE_LOST_MS * VTICK_HZ / 1000;
	// Frequency counters
	localparam int H_PERIODS = 64;
	localparam int HCNT_W = 14;
	localparam int VCNT_W = 12;
	localparam int CNT_OVF_POS = 15;
	// Register byte offsets
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_HCOUNT = 8'h04;
	localparam logic [7:0] ADR_VCOUNT = 8'h08;
	localparam logic [7:0] ADR_CTRL = 8'h0C;
	localparam logic [7:0] ADR_FLAGS = 8'h10;
	localparam logic [7:0] ADR_ENABLE = 8'h14;
	// Reset values
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [6:0] FLAGS_RST = 7'h00;
	localparam logic [6:0] ENABLE_RST = 7'h00;
	// Vertical source selection codes
	typedef enum logic [1:0] {
		SRC_OFF = 2'b00,
		SRC_AUTO = 2'b01,
		SRC_VSYNC = 2'b10,
		SRC_EXTR = 2'b11
	} src_e;
	// Control register layout, bits 7..6, 5, 1, 0 on the bus
	typedef struct packed {
		src_e sync_source_select;
		logic horizontal_blank_out_insert_disable;
		logic horizontal_blank_out_neg;
		logic vertical_blank_out_neg;
	} ctrl_s;
	// Event flags, bits 7..2 and 0 on the bus
	typedef struct packed {
		logic hpresence_change_flag;
		logic vpresence_change_flag;
		logic hpolarity_change_flag;
		logic vpolarity_change_flag;
		logic hfreq_change_flag;
		logic vfreq_change_flag;
		logic vsync_event_flag;
	} flags_s;
endpackage
`default_nettype wire

// ===== src/hv_sync_processor.sv
// H/V sync processor: presence, frequency, polarity, composite sync.
// Assumes sync inputs synchronous to clk_i and a classic Wishbone master.
//
// Summary of operation
// - Sync pulses only one clock period long are discarded as noise.
// - Hsync input watched; extracted vertical sync sets composite present.
// - Extracted vertical sync lags the composite input by eight microseconds.
// - During composite vsync, blank gets pulses one eighth of hsync period.
// - Insertion disable bit suppresses the inserted horizontal blank pulses.
// - 14-bit counter times sixty-four hsync periods, then latches result.
// - Horizontal count equals 128000000 over frequency, minus one.
// - Horizontal count loads per vsync when present, else per measurement.
// - Twelve-bit counter times interval between successive vsync pulses.
// - Vertical count equals 62500 over frequency, refreshed every vsync.
// - Each frequency counter carries an overflow indicator.
// - Frequency change flags set on value change or counter overflow.
// - Hsync present sets above 10 kHz, clears below 10 Hz.
// - Vsync present sets above 40 Hz, clears below 10 Hz.
// - Horizontal presence change flag sets whenever hsync present changes.
// - Vertical presence flag on vsync presence change, or on composite presence change unless source is off.
// - Longer high pulse reports negative polarity, otherwise positive.
// - Each polarity change flag sets when its own polarity changes.
// - Blank outputs are software selected muxes of sync sources.
// - Vsync event flag sets at each detected vertical sync leading edge.
// - Vsync event flag stays set until software writes zero.
// - Two-bit select picks extracted, vsync, disabled or automatic source.
// - Any enabled set flag drives the interrupt line low.
// - Writing zero clears a flag bit, writing one leaves it.
// - Set polarity control gives negative blank output, cleared positive.
`default_nettype none
module hv_sync_processor
	import hv_sync_pkg::*;
#(
	parameter int H_LOST_TICKS = HPRE_LOST_TICKS,
	parameter int V_LOST_TICKS = VPRE_LOST_TICKS
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsync_i,
	input wire logic vsync_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic horizontal_blank_out_o,
	output logic vertical_blank_out_o,
	output logic cpu_external_irq_line_n_o
);
	localparam int HL_W = $clog2(H_LOST_TICKS + 1);
	localparam int VL_W = $clog2(V_LOST_TICKS + 1);

	// Saturating 16-bit increment
	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	// Active level of a sync line for a given polarity
	function automatic logic act_lvl(input logic lvl, input logic pos);
		act_lvl = pos ? lvl : ~lvl;
	endfunction

	logic [7:0] div_h, div_v;
	logic htick, vtick;
	logic [1:0] in_q, filt, filt_q, src, src_q;
	logic [15:0] run [2], last_hi [2], last_lo [2];
	logic [1:0] pol, pol_q;
	logic hact, vact, vact_q, vlead, hrise, vrise;
	logic [4:0] act_run, inact_run;
	logic ext, ext_q, cv_pre, cv_pre_q;
	logic [VL_W-1:0] cv_lost;
	logic [HL_W-1:0] hper_lost;
	logic [15:0] hper, hper_last, ins_cnt;
	logic hpre, hpre_q, vpre, vpre_q;
	logic [15:0] vper;
	logic [VL_W-1:0] vper_lost;
	logic [15:0] hm_cnt;
	logic [5:0] hm_edges;
	logic [HCNT_W-1:0] h_meas, hfreq_count;
	logic h_meas_ovf, h_done, hovf;
	logic [15:0] vm_cnt;
	logic [VCNT_W-1:0] vfreq_count;
	logic vovf;
	logic [15:0] hm_total, vm_total;
	logic use_ext, vsel_pre, hload, hload_chg, vload_chg;
	ctrl_s ctrl;
	flags_s flags, flag_set, flag_clr;
	logic [6:0] en_reg;
	logic req, wr, ack_reg;

	// Count tick dividers
	always_ff @(posedge clk_i)
	begin
		if (rst_i || div_h == 8'(HTICK_DIV - 1))
			div_h <= 8'h00;
		else
			div_h <= div_h + 8'h01;
		if (rst_i || div_v == 8'(VTICK_DIV / 4 - 1))
			div_v <= 8'h00;
		else
			div_v <= div_v + 8'h01;
	end
	logic [1:0] vpre_div;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			vpre_div <= 2'b00;
		else if (div_v == 8'(VTICK_DIV / 4 - 1))
			vpre_div <= vpre_div + 2'b01;
	end
	assign htick = (div_h == 8'(HTICK_DIV - 1));
	assign vtick = (div_v == 8'(VTICK_DIV / 4 - 1)) && (vpre_div == 2'b11);

	// Noise filter: a level must be seen on two clocks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			in_q <= 2'b00;
			filt <= 2'b00;
			filt_q <= 2'b00;
		end
		else
		begin
			in_q <= {vsync_i, hsync_i};
			filt_q <= filt;
			for (int i = 0; i < 2; i++)
				if (in_q[i] == (i == 0 ? hsync_i : vsync_i))
					filt[i] <= in_q[i];
		end
	end
	assign hrise = filt[0] & ~filt_q[0];
	assign vrise = filt[1] & ~filt_q[1];

	// Vertical source choice
	always_comb
	begin
		unique case (ctrl.sync_source_select)
			SRC_EXTR: use_ext = 1'b1;
			SRC_AUTO: use_ext = cv_pre & ~vpre;
			SRC_VSYNC: use_ext = 1'b0;
			SRC_OFF: use_ext = 1'b0;
		endcase
	end
	assign src = {use_ext ? ext : filt[1], filt[0]};
	assign vsel_pre = use_ext ? cv_pre : vpre;

	// High and low pulse lengths, polarity from their compare
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			src_q <= 2'b00;
			pol <= 2'b11;
			pol_q <= 2'b11;
			for (int i = 0; i < 2; i++)
			begin
				run[i] <= 16'h0000;
				last_hi[i] <= 16'h0000;
				last_lo[i] <= 16'h0000;
			end
		end
		else
		begin
			src_q <= src;
			pol_q <= pol;
			for (int i = 0; i < 2; i++)
			begin
				if (src[i] != src_q[i])
				begin
					run[i] <= 16'h0000;
					if (src_q[i])
						last_hi[i] <= run[i];
					else
						last_lo[i] <= run[i];
				end
				else if (i == 0 ? htick : vtick)
					run[i] <= sat_inc(run[i]);
				pol[i] <= ~(last_hi[i] > last_lo[i]);
			end
		end
	end
	assign hact = act_lvl(filt[0], pol[0]);
	assign vact = act_lvl(src[1], pol[1]);
	assign vlead = vact & ~vact_q;

	// Composite extraction: broad active pulses, delayed
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			act_run <= 5'h00;
			inact_run <= 5'h00;
			ext <= 1'b0;
			ext_q <= 1'b0;
		end
		else
		begin
			ext_q <= ext;
			if (!hact)
				act_run <= 5'h00;
			else if (htick && act_run != 5'(EXTRACT_TICKS))
				act_run <= act_run + 5'h01;
			if (hact)
				inact_run <= 5'h00;
			else if (htick && inact_run != 5'(EXTRACT_TICKS))
				inact_run <= inact_run + 5'h01;
			if (act_run == 5'(EXTRACT_TICKS))
				ext <= 1'b1;
			else if (inact_run == 5'(EXTRACT_TICKS))
				ext <= 1'b0;
		end
	end

	// Composite present: set on extraction, cleared after silence
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cv_pre <= 1'b0;
			cv_lost <= '0;
		end
		else if (ext & ~ext_q)
		begin
			cv_pre <= 1'b1;
			cv_lost <= '0;
		end
		else if (cv_lost == VL_W'(V_LOST_TICKS))
			cv_pre <= 1'b0;
		else if (vtick)
			cv_lost <= cv_lost + VL_W'(1);
	end

	// Horizontal presence and last period
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hpre <= 1'b0;
			hper <= 16'h0000;
			hper_last <= 16'h0000;
			hper_lost <= '0;
		end
		else if (hrise)
		begin
			if (hper < 16'(HPRE_SET_TICKS))
				hpre <= 1'b1;
			hper_last <= hper;
			hper <= 16'h0000;
			hper_lost <= '0;
		end
		else
		begin
			if (hper_lost == HL_W'(H_LOST_TICKS))
				hpre <= 1'b0;
			else if (htick)
				hper_lost <= hper_lost + HL_W'(1);
			if (htick)
				hper <= sat_inc(hper);
		end
	end

	// Vertical presence on the vsync input
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vpre <= 1'b0;
			vper <= 16'h0000;
			vper_lost <= '0;
		end
		else if (vrise)
		begin
			if (vper < 16'(VPRE_SET_TICKS))
				vpre <= 1'b1;
			vper <= 16'h0000;
			vper_lost <= '0;
		end
		else
		begin
			if (vper_lost == VL_W'(V_LOST_TICKS))
				vpre <= 1'b0;
			else if (vtick)
				vper_lost <= vper_lost + VL_W'(1);
			if (vtick)
				vper <= sat_inc(vper);
		end
	end

	// Sixty-four period horizontal measurement
	// A tick on the closing edge still belongs to the window it ends
	assign hm_total = htick ? sat_inc(hm_cnt) : hm_cnt;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hm_cnt <= 16'h0000;
			hm_edges <= 6'h00;
			h_meas <= '0;
			h_meas_ovf <= 1'b0;
			h_done <= 1'b0;
		end
		else
		begin
			h_done <= 1'b0;
			if (hrise && hm_edges == 6'(H_PERIODS - 1))
			begin
				h_meas <= HCNT_W'(hm_total - 16'h0001);
				h_meas_ovf <= (hm_total > 16'(1 << HCNT_W));
				h_done <= 1'b1;
				hm_cnt <= 16'h0000;
				hm_edges <= 6'h00;
			end
			else
			begin
				if (hrise)
					hm_edges <= hm_edges + 6'h01;
				if (htick)
					hm_cnt <= sat_inc(hm_cnt);
			end
		end
	end

	// Horizontal count latch
	assign hload = vsel_pre ? vlead : h_done;
	assign hload_chg = hload && (h_meas != hfreq_count || h_meas_ovf);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hfreq_count <= '0;
			hovf <= 1'b0;
		end
		else if (hload)
		begin
			hfreq_count <= h_meas;
			hovf <= h_meas_ovf;
		end
	end

	// Vertical period counter and latch
	assign vm_total = vtick ? sat_inc(vm_cnt) : vm_cnt;
	assign vload_chg = vlead && (VCNT_W'(vm_total) != vfreq_count
		|| vm_total >= 16'(1 << VCNT_W));
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vm_cnt <= 16'h0000;
			vfreq_count <= '0;
			vovf <= 1'b0;
		end
		else if (vlead)
		begin
			vfreq_count <= VCNT_W'(vm_total);
			vovf <= (vm_total >= 16'(1 << VCNT_W));
			vm_cnt <= 16'h0000;
		end
		else if (vtick)
			vm_cnt <= sat_inc(vm_cnt);
	end

	// Inserted pulse timer, locked to hsync period
	always_ff @(posedge clk_i)
	begin
		if (rst_i || hrise)
			ins_cnt <= 16'h0000;
		else if (htick)
			ins_cnt <= (ins_cnt >= hper_last) ? 16'h0000 : ins_cnt + 16'h0001;
	end

	// Blank outputs: source mux and polarity
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			horizontal_blank_out_o <= 1'b0;
			vertical_blank_out_o <= 1'b0;
			vact_q <= 1'b0;
		end
		else
		begin
			vact_q <= vact;
			if (ctrl.sync_source_select != SRC_OFF && ext
				&& !ctrl.horizontal_blank_out_insert_disable)
				horizontal_blank_out_o <= (ins_cnt < (hper_last >> 3))
					^ ctrl.horizontal_blank_out_neg;
			else
				horizontal_blank_out_o <= hact ^ ctrl.horizontal_blank_out_neg;
			vertical_blank_out_o <= vact ^ ctrl.vertical_blank_out_neg;
		end
	end

	// Event sources for the flags
	always_comb
	begin
		flag_set.hpresence_change_flag = hpre != hpre_q;
		flag_set.vpresence_change_flag = (vpre != vpre_q)
			|| (ctrl.sync_source_select != SRC_OFF
			&& cv_pre != cv_pre_q);
		flag_set.hpolarity_change_flag = pol[0] != pol_q[0];
		flag_set.vpolarity_change_flag = pol[1] != pol_q[1];
		flag_set.hfreq_change_flag = hload_chg;
		flag_set.vfreq_change_flag = vload_chg;
		flag_set.vsync_event_flag = vlead;
		flag_clr = flags_s'(7'h00);
		if (wr && wb_adr_i == ADR_FLAGS && wb_sel_i[0])
			flag_clr = flags_s'(~{wb_dat_i[7:2], wb_dat_i[0]});
	end

	// Sticky flags, a new event wins over a clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			flags <= flags_s'(FLAGS_RST);
			hpre_q <= 1'b0;
			vpre_q <= 1'b0;
			cv_pre_q <= 1'b0;
		end
		else
		begin
			flags <= (flags & ~flag_clr) | flag_set;
			hpre_q <= hpre;
			vpre_q <= vpre;
			cv_pre_q <= cv_pre;
		end
	end

	// Interrupt request, low while any enabled flag is set
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cpu_external_irq_line_n_o <= 1'b1;
		else
			cpu_external_irq_line_n_o <= ~|(flags & en_reg);
	end

	// Wishbone slave: one wait state, ack for one cycle
	assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
	assign wr = req & wb_we_i;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl <= ctrl_s'(CTRL_RST);
			en_reg <= ENABLE_RST;
		end
		else if (wr && wb_sel_i[0])
		begin
			if (wb_adr_i == ADR_CTRL)
				ctrl <= ctrl_s'({wb_dat_i[7:5], wb_dat_i[1:0]});
			if (wb_adr_i == ADR_ENABLE)
				en_reg <= {wb_dat_i[7:2], wb_dat_i[0]};
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= req;
			wb_dat_o <= 32'h0000_0000;
			if (req && !wb_we_i)
				unique case (wb_adr_i)
					ADR_STATUS: wb_dat_o[7:0] <= {cv_pre, 1'b0, pol[0],
						pol[1], hpre, vsel_pre, filt[0], src[1]};
					ADR_HCOUNT: wb_dat_o[15:0] <= {hovf, 1'b0, hfreq_count};
					ADR_VCOUNT: wb_dat_o[15:0] <= {vovf, 3'h0, vfreq_count};
					ADR_CTRL: wb_dat_o[7:0] <= {ctrl[4:2], 3'h0, ctrl[1:0]};
					ADR_FLAGS: wb_dat_o[7:0] <= {flags[6:1], 1'b0, flags[0]};
					ADR_ENABLE: wb_dat_o[7:0] <= {en_reg[6:1], 1'b0, en_reg[0]};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
		end
	end
	assign wb_ack_o = ack_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wb_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_wb_done;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	chk_wb_answer: assert property (s_wb_req |=> s_wb_done)
		else $error("Bus request not answered by one-cycle ack");
	chk_noise_hold: assert property ((in_q[0] != hsync_i)
		|=> $stable(filt[0]))
		else $error("Single-cycle hsync glitch reached filter");
	chk_tick_space: assert property (htick |=> !htick [*8])
		else $error("Horizontal tick too frequent");
	chk_ext_rise: assert property ($rose(ext) |-> $past(hact, 2))
		else $error("Extraction without broad active pulse");
	chk_hpre_set: assert property ($rose(hpre) |-> $past(hrise))
		else $error("Hsync presence set without an edge");
	chk_vevent_set: assert property (vlead
		|=> flags.vsync_event_flag)
		else $error("Vsync event flag not set at leading edge");
	chk_vevent_hold: assert property (flags.vsync_event_flag
		&& !flag_clr[0] |=> flags.vsync_event_flag)
		else $error("Vsync event flag lost without clear");
	chk_irq_low: assert property (flags.vsync_event_flag
		&& en_reg[0] |-> ##[1:2] !cpu_external_irq_line_n_o)
		else $error("Enabled flag did not drive interrupt low");
	chk_hins_off: assert property (ctrl.horizontal_blank_out_insert_disable
		|=> horizontal_blank_out_o
		== ($past(hact) ^ $past(ctrl.horizontal_blank_out_neg)))
		else $error("Insert pulse present while disabled");
	chk_vertical_blank_out_pol: assert property (1'b1
		|=> vertical_blank_out_o
		== ($past(vact) ^ $past(ctrl.vertical_blank_out_neg)))
		else $error("Vertical blank polarity wrong");
	chk_hfreq_load: assert property (hload
		|=> hfreq_count == $past(h_meas))
		else $error("Horizontal count not loaded");
endmodule // hv_sync_processor
`default_nettype wire

// ===== tb/sync_source_model.sv
// Video source model: drives one sync line with a settable period,
// pulse width and polarity. Assumes it runs on the block's own clock.
`default_nettype none
module sync_source_model
(
	input wire logic clk_i,
	input wire logic run_i,
	input wire logic active_high_i,
	input wire logic [15:0] period_i,
	input wire logic [15:0] width_i,
	output logic sync_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] phase_reg;
	// Phase counter, restarts whenever the source is stopped
	always_ff @(posedge clk_i)
	begin
		if (!run_i || phase_reg >= period_i - 16'h0001)
			phase_reg <= 16'h0000;
		else
			phase_reg <= phase_reg + 16'h0001;
	end
	// Active level at the start of each period, idle level when stopped
	always_ff @(posedge clk_i)
	begin
		if (run_i && phase_reg < width_i)
			sync_o <= active_high_i;
		else
			sync_o <= !active_high_i;
	end
endmodule // sync_source_model
`default_nettype wire

// ===== tb/hv_sync_processor_tb_top.sv
// Testbench for the sync processor: register bus, counts, flags, blanks.
// Assumes the package constants and a 50 MHz clock.
`default_nettype none
module hv_sync_processor_tb_top
	import hv_sync_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, horizontal_blank_out, vertical_blank_out, irq_n, hsync_i, vsync_i;
	logic h_run = 1'b0;
	logic h_pos = 1'b1;
	logic v_run = 1'b0;
	logic v_pos = 1'b1;
	logic [15:0] h_per = 16'h00FA;
	logic [15:0] h_wid = 16'h0019;
	logic [15:0] v_per = 16'h2EE0;
	logic [15:0] v_wid = 16'h0320;
	logic [71:0] note_q[$];
	int errors = 0;
	int total_checks = 0;
	logic [31:0] r;
	logic [7:0] d;

	hv_sync_processor #(.H_LOST_TICKS(200), .V_LOST_TICKS(20))
		hv_sync_processor_i (.clk_i(clk_i), .rst_i(rst_i),
		.hsync_i(hsync_i), .vsync_i(vsync_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .horizontal_blank_out_o(horizontal_blank_out),
		.vertical_blank_out_o(vertical_blank_out),
		.cpu_external_irq_line_n_o(irq_n));
	sync_source_model h_source_i (.clk_i(clk_i), .run_i(h_run),
		.active_high_i(h_pos), .period_i(h_per), .width_i(h_wid),
		.sync_o(hsync_i));
	sync_source_model v_source_i (.clk_i(clk_i), .run_i(v_run),
		.active_high_i(v_pos), .period_i(v_per), .width_i(v_wid),
		.sync_o(vsync_i));

	// Clock, 20 ns period
	initial
	begin
		forever #10 clk_i = !clk_i;
	end

	task automatic check_read(input logic [71:0] n, input logic [31:0] g);
		total_checks++;
		if ((g & n[31:0]) !== n[63:32])
		begin
			errors++;
			$display("unexpected read %h expected %h seen %h", n[71:64],
				n[63:32], g & n[31:0]);
		end
	endtask

	task automatic check_pin(input string s, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s expected %b seen %b", s, e, g);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One classic cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] x, input logic [3:0] s);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= x;
		wb_sel_i <= s;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 100)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 100)
			errors++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		bus(1'b1, a, {r[31:8], x}, 4'hF);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		note_q.push_back({a, e, m});
		bus(1'b0, a, 32'h00000000, 4'hF);
	endtask

	// Compare every read answer with the oldest note
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && note_q.size() > 0)
			check_read(note_q.pop_front(), wb_dat_o);
	end

	// Watchdog
	initial
	begin
		repeat (99000) @(posedge clk_i);
		errors++;
		tally_and_finish();
	end

	// Main sequence
	initial
	begin
		r = $urandom(32'h535F92DC);
		idle(12);
		rst_i <= 1'b0;
		idle(1);
		rd(ADR_CTRL, 32'h0, 32'hFFFFFFFF);
		rd(ADR_FLAGS, 32'h0, 32'hFFFFFFFF);
		rd(ADR_ENABLE, 32'h0, 32'hFFFFFFFF);
		rd(8'h1C, 32'h0, 32'hFFFFFFFF);
		for (int c = 0; c < 4; c++)
		begin
			r = $urandom();
			d = {c[1:0], r[5], 3'b000, r[1:0]};
			wr(ADR_CTRL, d);
			rd(ADR_CTRL, {24'h0, d}, 32'hFFFFFFFF);
		end
		bus(1'b1, ADR_CTRL, 32'h00000023, 4'h0);
		rd(ADR_CTRL, {24'h0, d}, 32'hFFFFFFFF);
		wr(ADR_CTRL, 8'h00);
		wr(ADR_ENABLE, 8'hFD);
		h_run <= 1'b1;
		idle(36000);
		rd(ADR_HCOUNT, 64 * (250 / HTICK_DIV) - 1, 32'hFFFFFFFF);
		rd(ADR_STATUS, 32'h28, 32'h28);
		rd(ADR_FLAGS, 32'h88, 32'h88);
		check_pin("irq", 1'b0, irq_n);
		wr(ADR_ENABLE, 8'h00);
		idle(2);
		check_pin("irq", 1'b1, irq_n);
		wr(ADR_FLAGS, 8'h7F);
		rd(ADR_FLAGS, 32'h08, 32'h88);
		wr(ADR_FLAGS, 8'h00);
		rd(ADR_FLAGS, 32'h00, 32'hFF);
		wr(ADR_ENABLE, 8'hFD);
		idle(2);
		check_pin("irq", 1'b1, irq_n);
		h_pos <= 1'b0;
		idle(3000);
		rd(ADR_STATUS, 32'h08, 32'h28);
		rd(ADR_FLAGS, 32'h20, 32'h20);
		check_pin("irq", 1'b0, irq_n);
		wr(ADR_CTRL, 8'h80);
		v_run <= 1'b1;
		idle(30000);
		rd(ADR_VCOUNT, 12000 / VTICK_DIV, 32'hFFFFFFFF);
		rd(ADR_STATUS, 32'h14, 32'h14);
		rd(ADR_FLAGS, 32'h41, 32'h41);
		@(posedge vsync_i);
		idle(10);
		wr(ADR_FLAGS, 8'hFE);
		rd(ADR_FLAGS, 32'h40, 32'h41);
		h_pos <= 1'b1;
		idle(2000);
		wr(ADR_FLAGS, 8'h00);
		v_run <= 1'b0;
		h_wid <= 16'h0001;
		idle(20);
		check_pin("vertical_blank_out", 1'b0, vertical_blank_out);
		check_pin("horizontal_blank_out", 1'b0, horizontal_blank_out);
		wr(ADR_CTRL, 8'h83);
		idle(5);
		check_pin("vertical_blank_out", 1'b1, vertical_blank_out);
		check_pin("horizontal_blank_out", 1'b1, horizontal_blank_out);
		idle(6000);
		rd(ADR_STATUS, 32'h00, 32'h08);
		rd(ADR_FLAGS, 32'h80, 32'h80);
		wr(ADR_CTRL, 8'hC0);
		h_per <= 16'h0FA0;
		h_wid <= 16'h04B0;
		h_run <= 1'b1;
		@(posedge hsync_i);
		idle(300);
		check_pin("vertical_blank_out", 1'b0, vertical_blank_out);
		idle(250);
		check_pin("vertical_blank_out", 1'b1, vertical_blank_out);
		@(posedge hsync_i);
		idle(800);
		check_pin("horizontal_blank_out", 1'b0, horizontal_blank_out);
		wr(ADR_CTRL, 8'hE0);
		idle(5);
		check_pin("horizontal_blank_out", 1'b1, horizontal_blank_out);
		idle(10);
		tally_and_finish();
	end
endmodule // hv_sync_processor_tb_top
`default_nettype wire
